// ### rtl/tks_scanner.sv
`include "tks_consts.svh"
`default_nettype none
// How it works
// - charge line output, sense lines inputs
// - per-key counters cleared, count touched samples
// - measurement starts with charge line high
// - scan timer loads key delay, waits
// - sample on expiry, low means touched
// - one-shot 1 ms decay after sample
// - at most one key reported pressed
// - query over window returns key or idle
// - blocking get waits for press forever
// - release wait until all keys released
// - per-key delays 400, 500, 350 clocks
// - three consecutive touched samples mean pressed
// - ten untouched samples mean released
// - charge line rests low when idle
module tks_scanner
   import tks_pkg::*;
#(
   parameter logic [`TKS_TCNT_W-1:0] DECAY_CYCLES = `TKS_DECAY_CYC
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // pads
   input wire logic [`TKS_NUM_KEYS-1:0] key_sense,
   output logic pad_charge_line,
   output logic pad_charge_oe,
   // per-key sample delays
   input wire logic [`TKS_DLY_W-1:0] key_delay [`TKS_NUM_KEYS],
   // service requests
   input wire logic query_req,
   input wire logic [`TKS_TCNT_W-1:0] query_window,
   input wire logic get_req,
   input wire logic release_req,
   output logic svc_done,
   output logic [1:0] svc_key,
   // state view
   output logic [1:0] pressed_key,
   output logic [`TKS_HCNT_W-1:0] touch_count [`TKS_NUM_KEYS]
);

   // ------------------------------------------------------------
   // input synchroniser and state
   // ------------------------------------------------------------
   logic [`TKS_NUM_KEYS-1:0] s1_q, s2_q, s3_q, sense_q, pressed_q;
   tks_state_type state_q;
   logic [`TKS_DLY_W-1:0] scan_timer_q;
   logic [`TKS_TCNT_W-1:0] decay_timer_q, win_q;
   logic [1:0] key_idx_q, first_key;
   logic [3:0] hit_q [`TKS_NUM_KEYS], miss_q [`TKS_NUM_KEYS];
   tks_svc_type svc_q;
   logic sample_now, any_pressed;

   // three-flop sync, accept when stages two and three agree
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s1_q <= '1;
         s2_q <= '1;
         s3_q <= '1;
         sense_q <= '1;
      end
      else
      begin
         s1_q <= key_sense;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < `TKS_NUM_KEYS; i++)
            if (s2_q[i] == s3_q[i])
               sense_q[i] <= s3_q[i];
      end
   end

   // charge line always driven, sense lines input only
   assign pad_charge_oe = 1'b1;
   assign pad_charge_line = (state_q == TKS_CHARGE);
   assign sample_now = (state_q == TKS_CHARGE) && (scan_timer_q == '0);

   // ------------------------------------------------------------
   // scan sequencer
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= TKS_IDLE;
         scan_timer_q <= '0;
         decay_timer_q <= '0;
         key_idx_q <= 2'h0;
      end
      else
      begin
         case (state_q)
            TKS_IDLE:
            begin
               state_q <= TKS_CHARGE;
               scan_timer_q <= key_delay[key_idx_q];
            end
            TKS_CHARGE:
            begin
               if (scan_timer_q == '0)
               begin
                  state_q <= TKS_DECAY;
                  decay_timer_q <= DECAY_CYCLES - 1'b1;
               end
               else
                  scan_timer_q <= scan_timer_q - 1'b1;
            end
            TKS_DECAY:
            begin
               if (decay_timer_q == '0)
               begin
                  state_q <= TKS_IDLE;
                  key_idx_q <= (key_idx_q == 2'(`TKS_NUM_KEYS - 1)) ?
                     2'h0 : key_idx_q + 2'h1;
               end
               else
                  decay_timer_q <= decay_timer_q - 1'b1;
            end
            default:
               state_q <= TKS_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // per-key debounce and touch counters
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pressed_q <= '0;
         for (int i = 0; i < `TKS_NUM_KEYS; i++)
         begin
            hit_q[i] <= 4'h0;
            miss_q[i] <= 4'h0;
            touch_count[i] <= '0;
         end
      end
      else if (sample_now)
      begin
         for (int i = 0; i < `TKS_NUM_KEYS; i++)
            if (key_idx_q == 2'(i))
            begin
               if (!sense_q[i])
               begin
                  touch_count[i] <= touch_count[i] + 1'b1;
                  miss_q[i] <= 4'h0;
                  if (hit_q[i] != `TKS_PRESS_CNT)
                     hit_q[i] <= hit_q[i] + 4'h1;
                  if (hit_q[i] == `TKS_PRESS_CNT - 4'h1)
                     pressed_q[i] <= 1'b1;
               end
               else
               begin
                  hit_q[i] <= 4'h0;
                  if (miss_q[i] != `TKS_RELEASE_CNT)
                     miss_q[i] <= miss_q[i] + 4'h1;
                  if (miss_q[i] == `TKS_RELEASE_CNT - 4'h1)
                     pressed_q[i] <= 1'b0;
               end
            end
      end
   end

   // lowest pressed key wins, others hidden
   always_comb
   begin
      first_key = `TKS_NO_KEY;
      for (int i = `TKS_NUM_KEYS - 1; i >= 0; i--)
         if (pressed_q[i])
            first_key = 2'(i);
   end
   assign any_pressed = |pressed_q;

   // reported key register
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         pressed_key <= `TKS_NO_KEY;
      else
         pressed_key <= first_key;
   end

   // ------------------------------------------------------------
   // services: query, get, release wait
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         svc_q <= TKS_SV_NONE;
         win_q <= '0;
         svc_done <= 1'b0;
         svc_key <= `TKS_NO_KEY;
      end
      else
      begin
         svc_done <= 1'b0;
         case (svc_q)
            TKS_SV_NONE:
            begin
               if (query_req)
               begin
                  svc_q <= TKS_SV_QUERY;
                  win_q <= query_window;
               end
               else if (get_req)
                  svc_q <= TKS_SV_GET;
               else if (release_req)
                  svc_q <= TKS_SV_REL;
            end
            TKS_SV_QUERY:
            begin
               if (any_pressed || win_q == '0)
               begin
                  svc_done <= 1'b1;
                  svc_key <= first_key;
                  svc_q <= TKS_SV_NONE;
               end
               else
                  win_q <= win_q - 1'b1;
            end
            TKS_SV_GET:
               if (any_pressed)
               begin
                  svc_done <= 1'b1;
                  svc_key <= first_key;
                  svc_q <= TKS_SV_NONE;
               end
            TKS_SV_REL:
               if (!any_pressed)
               begin
                  svc_done <= 1'b1;
                  svc_key <= `TKS_NO_KEY;
                  svc_q <= TKS_SV_NONE;
               end
            default:
               svc_q <= TKS_SV_NONE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_CHARGE_LOW_DECAY: assert property (@(posedge core_clk)
      disable iff (!resetn)
      state_q == TKS_DECAY |-> !pad_charge_line)
      else $error("charge line high during decay");
   AST_SAMPLE_TO_DECAY: assert property (@(posedge core_clk)
      disable iff (!resetn) sample_now |=> state_q == TKS_DECAY)
      else $error("decay did not follow sample");
   AST_CHARGE_START: assert property (@(posedge core_clk)
      disable iff (!resetn)
      state_q == TKS_IDLE |=> pad_charge_line
         && scan_timer_q == $past(key_delay[key_idx_q]))
      else $error("scan timer not loaded with key delay");
   AST_ONE_KEY: assert property (@(posedge core_clk)
      disable iff (!resetn)
      any_pressed && !sample_now |=> pressed_key != `TKS_NO_KEY
         && pressed_q[pressed_key]
         && (pressed_q & ((3'h1 << pressed_key) - 3'h1)) == 3'h0)
      else $error("reported key not pressed");
   AST_GET_WAITS: assert property (@(posedge core_clk)
      disable iff (!resetn)
      svc_q == TKS_SV_GET && !any_pressed |=> !svc_done)
      else $error("get finished with no press");
   AST_REL_WAITS: assert property (@(posedge core_clk)
      disable iff (!resetn)
      svc_q == TKS_SV_REL && any_pressed |=> !svc_done)
      else $error("release finished while pressed");
   AST_QUERY_ENDS: assert property (@(posedge core_clk)
      disable iff (!resetn)
      svc_q == TKS_SV_QUERY && win_q == '0 |=> svc_done)
      else $error("query did not end at window");
   AST_COUNT_TOUCH: assert property (@(posedge core_clk)
      disable iff (!resetn)
      sample_now && !sense_q[key_idx_q] |=>
         touch_count[$past(key_idx_q)] ==
         $past(touch_count[key_idx_q]) + 1'b1)
      else $error("touch counter not advanced");
   AST_ROUND_ROBIN: assert property (@(posedge core_clk)
      disable iff (!resetn)
      state_q == TKS_DECAY && decay_timer_q == '0 |=>
         key_idx_q == ($past(key_idx_q) + 2'h1) % 2'(`TKS_NUM_KEYS))
      else $error("key index did not advance");
   COV_PRESS: cover property (@(posedge core_clk) $rose(any_pressed));
   COV_RELEASE: cover property (@(posedge core_clk) $fell(any_pressed));
   COV_QUERY: cover property (@(posedge core_clk)
      svc_q == TKS_SV_QUERY ##1 svc_done);
endmodule // tks_scanner
`default_nettype wire

// ### include/tks_consts.svh
`ifndef TKS_CONSTS_SVH
`define TKS_CONSTS_SVH
// ------------------------------------------------------------
// scanner constants
// ------------------------------------------------------------
`define TKS_CLK_MHZ 125
`define TKS_DECAY_US 1000
`define TKS_DECAY_CYC (`TKS_DECAY_US * `TKS_CLK_MHZ)
`define TKS_NUM_KEYS 3
`define TKS_DLY_W 16
`define TKS_DLY_KEY0 16'h0190
`define TKS_DLY_KEY1 16'h01F4
`define TKS_DLY_KEY2 16'h015E
`define TKS_PRESS_CNT 4'h3
`define TKS_RELEASE_CNT 4'hA
`define TKS_NO_KEY 2'h3
`define TKS_TCNT_W 32
`define TKS_HCNT_W 16
`endif

// ### include/tks_pkg.sv
`default_nettype none
package tks_pkg;
   // scan sequencer states
   typedef enum logic [1:0] {TKS_IDLE, TKS_CHARGE, TKS_DECAY} tks_state_type;
   // service request state
   typedef enum logic [1:0] {TKS_SV_NONE, TKS_SV_QUERY, TKS_SV_GET,
      TKS_SV_REL} tks_svc_type;
endpackage
`default_nettype wire

// ### dv/tks_pad_model.sv
`include "tks_consts.svh"
`default_nettype none
// ----------------------------------------
// touch pads with series charge resistors
// ----------------------------------------
module tks_pad_model
#(
   parameter int RISE_FREE = 100,
   parameter int RISE_TOUCH = 2000
)
(
   // clock
   input wire logic core_clk,
   // charge drive and finger state
   input wire logic pad_charge_line,
   input wire logic pad_charge_oe,
   input wire logic [`TKS_NUM_KEYS-1:0] touched,
   // sense lines
   output logic [`TKS_NUM_KEYS-1:0] key_sense
);
   timeunit 1ns;
   timeprecision 1ps;
   int rise_cnt = 0;
   // pad voltage climbs only while the line is driven high
   always @(posedge core_clk)
   begin
      if (pad_charge_line && pad_charge_oe)
         rise_cnt <= rise_cnt + 1;
      else
         rise_cnt <= 0;
   end
   // a finger slows the rise; discharged pads read low
   always_comb
   begin
      for (int i = 0; i < `TKS_NUM_KEYS; i++)
         key_sense[i] = rise_cnt >= (touched[i] ? RISE_TOUCH : RISE_FREE);
   end
endmodule // tks_pad_model
`default_nettype wire

// ### dv/tb.sv
`include "tks_consts.svh"
`default_nettype none
// ----------------------------------------
// scanner testbench
// ----------------------------------------
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DECAY = 20;
   localparam int ROUND = 1253 + 3 * (DECAY + 1);
   localparam int QRY = 0, GET = 1, REL = 2;
   logic core_clk = 0, resetn = 0;
   logic [2:0] touched = 0, key_sense;
   logic pad_charge_line, pad_charge_oe, svc_done;
   logic [`TKS_DLY_W-1:0] key_delay [`TKS_NUM_KEYS];
   logic [2:0] svc_reqs = 3'h0;
   logic [`TKS_TCNT_W-1:0] query_window = 0;
   logic [1:0] svc_key, pressed_key;
   logic [`TKS_HCNT_W-1:0] touch_count [`TKS_NUM_KEYS];
   logic [31:0] lfsr = 32'hBF7F440E;
   int fail_count = 0, n_compared = 0, cycles = 0, hi, lo, n, k;
   assign key_delay = '{`TKS_DLY_KEY0, `TKS_DLY_KEY1, `TKS_DLY_KEY2};
   tks_scanner #(.DECAY_CYCLES(DECAY)) uut (.core_clk(core_clk),
      .resetn(resetn), .key_sense(key_sense),
      .pad_charge_line(pad_charge_line), .pad_charge_oe(pad_charge_oe),
      .key_delay(key_delay), .query_req(svc_reqs[QRY]),
      .query_window(query_window), .get_req(svc_reqs[GET]),
      .release_req(svc_reqs[REL]), .svc_done(svc_done), .svc_key(svc_key),
      .pressed_key(pressed_key), .touch_count(touch_count));
   tks_pad_model pads (.core_clk(core_clk),
      .pad_charge_line(pad_charge_line), .pad_charge_oe(pad_charge_oe),
      .touched(touched), .key_sense(key_sense));
   // clock and hang guard
   always #4 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         fail_count++;
         give_verdict();
      end
   end
   function automatic logic [31:0] next_rand(input logic [31:0] r);
      return {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
   endfunction
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
      end
   endtask
   // pulse a request, count cycles to the done pulse
   task automatic service(input int which, input int lim, output int cnt);
      @(posedge core_clk) svc_reqs <= 3'h1 << which;
      @(posedge core_clk) svc_reqs <= 3'h0;
      cnt = 0;
      do
      begin
         @(negedge core_clk);
         cnt++;
      end
      while (svc_done !== 1'b1 && cnt < lim);
      chk("svc_done", 1, svc_done);
   endtask
   // widths of one charge pulse and the gap after it
   task automatic measure(output int h, output int l);
      while (pad_charge_line !== 1'b1) @(negedge core_clk);
      h = 0;
      l = 0;
      while (pad_charge_line === 1'b1)
      begin
         h++;
         @(negedge core_clk);
      end
      while (pad_charge_line !== 1'b1)
      begin
         l++;
         @(negedge core_clk);
      end
   endtask
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // main sequence
   initial
   begin
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      chk("charge at reset", 0, pad_charge_line);
      chk("charge oe", 1, pad_charge_oe);
      chk("svc_key at reset", `TKS_NO_KEY, svc_key);
      chk("pressed at reset", `TKS_NO_KEY, pressed_key);
      for (int i = 0; i < 3; i++)
         chk("count at reset", 0, touch_count[i]);
      @(posedge core_clk) resetn <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         measure(hi, lo);
         chk("charge high", key_delay[i] + 1, hi);
         chk("charge low", DECAY + 1, lo);
      end
      lfsr = next_rand(lfsr);
      @(posedge core_clk) query_window <= 30 + lfsr[5:0];
      service(QRY, 400, n);
      chk("idle query key", `TKS_NO_KEY, svc_key);
      chk("query span", 1, n >= query_window && n <= query_window + 3);
      lfsr = next_rand(lfsr);
      k = lfsr % 3;
      while (pad_charge_line === 1'b1) @(negedge core_clk);
      @(posedge core_clk) touched[k] <= 1'b1;
      service(GET, 20000, n);
      chk("get key", k, svc_key);
      chk("pressed key", k, pressed_key);
      chk("press delay", 1, n > 2 * ROUND && n < 3 * ROUND);
      chk("touch count", 3, touch_count[k]);
      service(QRY, 400, n);
      chk("busy query key", k, svc_key);
      chk("busy query span", 2, n);
      @(posedge core_clk) touched <= 3'h0;
      service(REL, 20000, n);
      chk("released", `TKS_NO_KEY, pressed_key);
      chk("release key", `TKS_NO_KEY, svc_key);
      chk("release delay", 1, n > 9 * ROUND && n < 10 * ROUND);
      chk("count kept", 3, touch_count[k]);
      // touch lands in key k's decay, so the first touched key scanned after k wins
      @(posedge core_clk) touched <= 3'h6;
      service(GET, 20000, n);
      chk("two key get", (k == 1) ? 2 : 1, svc_key);
      repeat (ROUND) @(posedge core_clk);
      service(QRY, 400, n);
      chk("two key query", 1, svc_key);
      chk("two key pressed", 1, pressed_key);
      @(posedge core_clk) touched <= 3'h0;
      service(REL, 20000, n);
      chk("all released", `TKS_NO_KEY, pressed_key);
      give_verdict();
   end
endmodule // tb
`default_nettype wire
